// ===== lss_host_model.sv
`timescale 1ns/100ps
module lss_host_model (
   input  wire logic       clk_i,
   input  wire logic [2:0] want_i,
   input  wire logic       rearm_i,
   output logic            nro_o = 1'b0,
   output logic            drv_a_o = 1'b0,
   output logic            drv_b_o = 1'b0
);
   // pins move one clock after the request
   always_ff @(posedge clk_i) begin
      nro_o   <= want_i[2];
      drv_a_o <= want_i[1] & ~rearm_i;
      drv_b_o <= want_i[0] & ~rearm_i;
   end
endmodule // lss_host_model

// ===== lss_pkg.sv
package lss_pkg;
   localparam int unsigned CLK_HZ             = 20_000_000;
   localparam int unsigned NUM_CH             = 5;
   // channel index: 0..4 = channels 1..5
   localparam int unsigned CH1                = 0;
   localparam int unsigned CH2                = 1;
   localparam int unsigned CH3                = 2;
   localparam int unsigned CH4                = 3;
   localparam int unsigned CH5                = 4;
   // command register bit positions
   localparam int unsigned CMD_CH2_BIT        = 0;
   localparam int unsigned CMD_CH4_BIT        = 1;
   localparam int unsigned CMD_CH5_BIT        = 2;
   // register offsets
   localparam logic [3:0]  REG_CMD            = 4'h0;
   localparam logic [3:0]  REG_STAT           = 4'h1;
   localparam logic [3:0]  REG_DIAGNOSIS_REGISTER_OC        = 4'h2;
   localparam logic [3:0]  REG_DIAGNOSIS_REGISTER_OT        = 4'h3;
   localparam logic [3:0]  REG_DIAGNOSIS_REGISTER_OL        = 4'h4;
   localparam logic [3:0]  REG_IRQ_STAT       = 4'h5;
   localparam logic [3:0]  REG_IRQ_MASK       = 4'h6;
   localparam logic [3:0]  REG_DIAGNOSIS_REGISTER_CMD       = 4'h7;
   // reset values
   localparam logic [7:0]  CMD_RST            = 8'h00;
   localparam logic [7:0]  IRQ_MASK_RST       = 8'h00;
   // irq status bits
   localparam int unsigned IRQ_OC_BIT         = 0;
   localparam int unsigned IRQ_OT_BIT         = 1;
   localparam int unsigned IRQ_OL_BIT         = 2;
   // times
   localparam real         OC_FILTER_US       = 2.0;
   localparam real         OC_RETRY_OFF_MS    = 5.0;
   localparam real         OC_STATUS_HOLD_MS  = 1.0;
   localparam real         OPEN_LOAD_DELAY_US = 100.0;
   localparam int unsigned OC_FILTER_CYC      = int'(OC_FILTER_US * CLK_HZ / 1.0e6);
   localparam int unsigned OC_RETRY_OFF_CYC   = int'(OC_RETRY_OFF_MS * CLK_HZ / 1.0e3);
   localparam int unsigned OC_STATUS_HOLD_CYC = int'(OC_STATUS_HOLD_MS * CLK_HZ / 1.0e3);
   localparam int unsigned OPEN_LOAD_DLY_CYC  = int'(OPEN_LOAD_DELAY_US * CLK_HZ / 1.0e6);

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } lss_bus_req_s;

   typedef struct packed {
      logic [4:0] overcurrent;
      logic [4:0] overtemp;
      logic [4:0] below_ol_threshold;
   } lss_sense_s;

   typedef enum logic [1:0] {
      RETRY_ON    = 2'b00,
      RETRY_OFF   = 2'b01,
      RETRY_HOLD  = 2'b10
   } lss_retry_e;
endpackage

// ===== lss_top.sv
// Operation
// - channels off while reset output low
// - channels 1/3 on by rising edge only
// - cmd bits 0,1,2 drive channels 2,4,5
// - overcurrent switches channel off
// - overcurrent off state latched, channels 1,3,4,5
// - cmd write after diagnosis_register read clears 4/5
// - channel 2 auto retry after off time
// - channel 2 oc bit held until on for hold time
// - status bits 0-4 show channel state
// - overtemperature off, auto resume after clear
// - channels 4 and 5 share thermal off
// - open load only channels 1,3,4,5 off
// - open load flagged after timer delay
// - overcurrent filtered for filter time
// - diagnosis registers readable by software
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module lss_top #(
   parameter int unsigned RETRY_OFF_CYC   = lss_pkg::OC_RETRY_OFF_CYC,
   parameter int unsigned STATUS_HOLD_CYC = lss_pkg::OC_STATUS_HOLD_CYC
) (
   input  wire logic                 clk_sys_i,
   input  wire logic                 sys_rst_i,
   input  wire logic                 reset_output_low_active_i,
   input  wire logic                 injector_drive_input_a_i,
   input  wire logic                 valve_drive_input_b_i,
   input  wire lss_pkg::lss_sense_s  sense_i,
   input  wire logic [3:0]           bus_addr_i,
   input  wire logic [7:0]           bus_wdata_i,
   input  wire logic                 bus_wr_i,
   input  wire logic                 bus_rd_i,
   output logic [7:0]                bus_rdata_o,
   output logic [4:0]                channel_on_o,
   output logic [4:0]                diagnosis_register_pulldown_o,
   output logic                      irq_o
);
   import lss_pkg::*;

   logic [7:0]  cmd_q;
   logic [7:0]  irq_mask_q;
   logic [2:0]  irq_stat_q;
   logic [4:0]  oc_latch_q;
   logic [4:0]  ol_flag_q;
   logic [4:0]  ch_q;
   logic        in_a_q;
   logic        in_b_q;
   logic        want_a_q;
   logic        want_b_q;
   logic        diagnosis_register_read_seen_q;
   logic [4:0]  oc_filt_hit;
   logic [4:0]  ot_eff;
   logic [4:0]  req;
   logic        ch2_block;
   logic        oc_clear45;
   logic [7:0]  rdata_d;
   lss_retry_e  retry_q;
   logic [31:0] retry_cnt_q;
   logic        nro_active;

   assign nro_active = ~reset_output_low_active_i;
   assign oc_clear45 = bus_wr_i && (bus_addr_i == REG_CMD) && diagnosis_register_read_seen_q;

   // overcurrent filter, one counter per channel
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ocf
         logic [7:0] cnt_q;
         always_ff @(posedge clk_sys_i) begin
            if (sys_rst_i || !sense_i.overcurrent[g] || !ch_q[g]) begin
               cnt_q <= 8'h00;
            end else if (cnt_q != OC_FILTER_CYC[7:0]) begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
         assign oc_filt_hit[g] = (cnt_q == OC_FILTER_CYC[7:0]);
      end
   endgenerate

   // open load timers
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ol
         if (g == CH2) begin : g_none
            // no open load detection on this channel
            assign diagnosis_register_pulldown_o[g] = 1'b0;
            assign ol_flag_q[g]       = 1'b0;
         end else begin : g_det
            logic [11:0] cnt_q;
            logic        flag_q;
            assign diagnosis_register_pulldown_o[g] = ~ch_q[g];
            assign ol_flag_q[g]       = flag_q;
            always_ff @(posedge clk_sys_i) begin
               if (sys_rst_i || ch_q[g] || !sense_i.below_ol_threshold[g]) begin
                  cnt_q  <= 12'h000;
                  flag_q <= 1'b0;
               end else if (cnt_q != OPEN_LOAD_DLY_CYC[11:0]) begin
                  cnt_q <= cnt_q + 12'h001;
               end else begin
                  flag_q <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // shared sensor for channels 4 and 5
   always_comb begin
      ot_eff      = sense_i.overtemp;
      ot_eff[CH4] = sense_i.overtemp[CH4] | sense_i.overtemp[CH5];
      ot_eff[CH5] = ot_eff[CH4];
   end

   // drive inputs: rising edge arms, low level clears latch
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || nro_active) begin
         in_a_q   <= 1'b1;
         in_b_q   <= 1'b1;
         want_a_q <= 1'b0;
         want_b_q <= 1'b0;
      end else begin
         in_a_q <= injector_drive_input_a_i;
         in_b_q <= valve_drive_input_b_i;
         if (!injector_drive_input_a_i) begin
            want_a_q <= 1'b0;
         end else if (!in_a_q) begin
            want_a_q <= 1'b1;
         end
         if (!valve_drive_input_b_i) begin
            want_b_q <= 1'b0;
         end else if (!in_b_q) begin
            want_b_q <= 1'b1;
         end
      end
   end

   // overcurrent latches
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         oc_latch_q <= 5'h00;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (oc_filt_hit[i]) begin
               oc_latch_q[i] <= 1'b1;
            end
         end
         if (!injector_drive_input_a_i && !oc_filt_hit[CH1]) begin
            oc_latch_q[CH1] <= 1'b0;
         end
         if (!valve_drive_input_b_i && !oc_filt_hit[CH3]) begin
            oc_latch_q[CH3] <= 1'b0;
         end
         if (oc_clear45) begin
            if (!oc_filt_hit[CH4]) begin
               oc_latch_q[CH4] <= 1'b0;
            end
            if (!oc_filt_hit[CH5]) begin
               oc_latch_q[CH5] <= 1'b0;
            end
         end
         if (retry_q == RETRY_HOLD && retry_cnt_q >= STATUS_HOLD_CYC && !oc_filt_hit[CH2]) begin
            oc_latch_q[CH2] <= 1'b0;
         end
      end
   end

   // channel 2 auto retry
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         retry_q     <= RETRY_ON;
         retry_cnt_q <= 32'h0000_0000;
      end else begin
         case (retry_q)
            RETRY_ON: begin
               retry_cnt_q <= 32'h0000_0000;
               if (oc_filt_hit[CH2]) begin
                  retry_q <= RETRY_OFF;
               end
            end
            RETRY_OFF: begin
               if (retry_cnt_q >= RETRY_OFF_CYC - 1) begin
                  retry_q     <= RETRY_HOLD;
                  retry_cnt_q <= 32'h0000_0000;
               end else begin
                  retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
               end
            end
            RETRY_HOLD: begin
               if (oc_filt_hit[CH2]) begin
                  retry_q     <= RETRY_OFF;
                  retry_cnt_q <= 32'h0000_0000;
               end else if (!ch_q[CH2]) begin
                  retry_cnt_q <= 32'h0000_0000;
               end else if (retry_cnt_q < STATUS_HOLD_CYC) begin
                  retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
               end else begin
                  retry_q <= RETRY_ON;
               end
            end
            default: begin
               retry_q <= RETRY_ON;
            end
         endcase
      end
   end

   assign ch2_block = (retry_q == RETRY_OFF);

   always_comb begin
      req      = 5'h00;
      req[CH1] = want_a_q && !oc_latch_q[CH1];
      req[CH3] = want_b_q && !oc_latch_q[CH3];
      req[CH2] = cmd_q[CMD_CH2_BIT] && !ch2_block;
      req[CH4] = cmd_q[CMD_CH4_BIT] && !oc_latch_q[CH4];
      req[CH5] = cmd_q[CMD_CH5_BIT] && !oc_latch_q[CH5];
   end

   // channel outputs
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || nro_active) begin
         ch_q <= 5'h00;
      end else begin
         ch_q <= req & ~ot_eff & ~oc_filt_hit;
      end
   end
   assign channel_on_o = ch_q;

   // command register and diagnosis-read tracking
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || nro_active) begin
         cmd_q            <= CMD_RST;
         diagnosis_register_read_seen_q <= 1'b0;
      end else begin
         if (bus_wr_i && bus_addr_i == REG_CMD) begin
            cmd_q            <= bus_wdata_i;
            diagnosis_register_read_seen_q <= 1'b0;
         end else if (bus_wr_i && bus_addr_i == REG_DIAGNOSIS_REGISTER_CMD) begin
            diagnosis_register_read_seen_q <= 1'b1;
         end else if (bus_rd_i && bus_addr_i == REG_DIAGNOSIS_REGISTER_OC) begin
            diagnosis_register_read_seen_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         irq_mask_q <= IRQ_MASK_RST;
      end else if (bus_wr_i && bus_addr_i == REG_IRQ_MASK) begin
         irq_mask_q <= bus_wdata_i;
      end
   end

   // sticky events, set wins over read-clear
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         irq_stat_q <= 3'h0;
      end else begin
         if (bus_rd_i && bus_addr_i == REG_IRQ_STAT) begin
            irq_stat_q <= 3'h0;
         end
         if (|oc_filt_hit) begin
            irq_stat_q[IRQ_OC_BIT] <= 1'b1;
         end
         if (|(ot_eff & req)) begin
            irq_stat_q[IRQ_OT_BIT] <= 1'b1;
         end
         if (|ol_flag_q) begin
            irq_stat_q[IRQ_OL_BIT] <= 1'b1;
         end
      end
   end
   assign irq_o = |(irq_stat_q & irq_mask_q[2:0]);

   always_comb begin
      rdata_d = 8'h00;
      if (bus_addr_i == REG_CMD) begin
         rdata_d = cmd_q;
      end else if (bus_addr_i == REG_STAT) begin
         rdata_d = {3'b000, ch_q};
      end else if (bus_addr_i == REG_DIAGNOSIS_REGISTER_OC) begin
         rdata_d = {3'b000, oc_latch_q};
      end else if (bus_addr_i == REG_DIAGNOSIS_REGISTER_OT) begin
         rdata_d = {3'b000, ot_eff};
      end else if (bus_addr_i == REG_DIAGNOSIS_REGISTER_OL) begin
         rdata_d = {3'b000, ol_flag_q};
      end else if (bus_addr_i == REG_IRQ_STAT) begin
         rdata_d = {5'b00000, irq_stat_q};
      end else if (bus_addr_i == REG_IRQ_MASK) begin
         rdata_d = irq_mask_q;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         bus_rdata_o <= 8'h00;
      end else if (bus_rd_i) begin
         bus_rdata_o <= rdata_d;
      end else begin
         bus_rdata_o <= 8'h00;
      end
   end
endmodule // lss_top

// ===== lss_top_props.sv
`timescale 1ns/100ps
module lss_top_props #(
   parameter int unsigned RETRY_OFF_CYC   = 50,
   parameter int unsigned STATUS_HOLD_CYC = 20
) (
   input wire logic               clk_sys_i,
   input wire logic               sys_rst_i,
   input wire logic               reset_output_low_active_i,
   input wire logic               injector_drive_input_a_i,
   input wire logic               valve_drive_input_b_i,
   input wire lss_pkg::lss_sense_s sense_i,
   input wire logic [3:0]         bus_addr_i,
   input wire logic [7:0]         bus_wdata_i,
   input wire logic               bus_wr_i,
   input wire logic               bus_rd_i,
   input wire logic [7:0]         bus_rdata_o,
   input wire logic [4:0]         channel_on_o,
   input wire logic [4:0]         diagnosis_register_pulldown_o,
   input wire logic               irq_o
);
   import lss_pkg::*;
   localparam int RET_MAX = RETRY_OFF_CYC + 4;
   logic [7:0] oc_cnt_q;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // cycles channel 1 has been on under overcurrent
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !(sense_i.overcurrent[0] && channel_on_o[0]))
         oc_cnt_q <= 8'h00;
      else
         oc_cnt_q <= oc_cnt_q + 8'h01;
   end
   rst_forces_off_a: assert property (
      !reset_output_low_active_i |=> channel_on_o == 5'h00) else $error("on during reset");
   pulldown_off_a: assert property (
      diagnosis_register_pulldown_o == {~channel_on_o[4:2], 1'b0, ~channel_on_o[0]}) else $error("pulldown");
   oc_filter_bound_a: assert property (oc_cnt_q <= 8'd60) else $error("oc not cut");
   oc_latch_hold_a: assert property (
      $fell(channel_on_o[0]) && sense_i.overcurrent[0] |=> !channel_on_o[0] [*2])
      else $error("latch lost");
   ch2_retry_a: assert property (
      $fell(channel_on_o[1]) && sense_i.overcurrent[1]
      |=> !channel_on_o[1] [*8] ##[1:RET_MAX] channel_on_o[1]) else $error("no retry");
   rdata_idle_a: assert property (!bus_rd_i |=> bus_rdata_o == 8'h00) else $error("rdata");
   ot_shared_off_a: assert property (
      (sense_i.overtemp[3] || sense_i.overtemp[4]) [*2] |=> channel_on_o[4:3] == 2'b00)
      else $error("ot pair");
   edge_on_a: assert property (
      $rose(channel_on_o[0]) |-> $past(injector_drive_input_a_i)) else $error("on no input");
endmodule // lss_top_props
bind lss_top lss_top_props #(
   .RETRY_OFF_CYC(RETRY_OFF_CYC), .STATUS_HOLD_CYC(STATUS_HOLD_CYC)
) u_lss_top_props (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
   .reset_output_low_active_i(reset_output_low_active_i),
   .injector_drive_input_a_i(injector_drive_input_a_i),
   .valve_drive_input_b_i(valve_drive_input_b_i), .sense_i(sense_i),
   .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
   .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .channel_on_o(channel_on_o),
   .diagnosis_register_pulldown_o(diagnosis_register_pulldown_o), .irq_o(irq_o)
);

// ===== tb_lss_top.sv
`timescale 1ns/100ps
module tb_lss_top;
   import lss_pkg::*;
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, wr = 1'b0, rd = 1'b0, rearm = 1'b0;
   logic [2:0] want = 3'b000;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00, rdata;
   logic [4:0] ch, pd;
   logic irq, reset_output_low_active, drv_a, drv_b;
   lss_sense_s sns = '0;
   int errors = 0, checks_done = 0;
   int unsigned map[3] = '{CH2, CH4, CH5};
   initial forever #25 clk_sys_i = ~clk_sys_i;
   lss_host_model u_lss_host_model (.clk_i(clk_sys_i), .want_i(want), .rearm_i(rearm),
      .nro_o(reset_output_low_active), .drv_a_o(drv_a), .drv_b_o(drv_b));
   lss_top #(.RETRY_OFF_CYC(50), .STATUS_HOLD_CYC(20)) u_lss_top (.clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i), .reset_output_low_active_i(reset_output_low_active),
      .injector_drive_input_a_i(drv_a), .valve_drive_input_b_i(drv_b), .sense_i(sns),
      .bus_addr_i(addr), .bus_wdata_i(wd), .bus_wr_i(wr), .bus_rd_i(rd),
      .bus_rdata_o(rdata), .channel_on_o(ch), .diagnosis_register_pulldown_o(pd), .irq_o(irq));
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic wrt(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i) begin
         addr <= a;
         wd <= d;
         wr <= 1'b1;
      end
      @(posedge clk_sys_i) wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk_sys_i) begin
         addr <= a;
         rd <= 1'b1;
      end
      @(posedge clk_sys_i) rd <= 1'b0;
      @(negedge clk_sys_i) chk(rdata & m, e);
   endtask
   task automatic chk_ch(input logic [7:0] e);
      @(negedge clk_sys_i) chk({3'h0, ch}, e);
   endtask
   task automatic ichk(input logic e);
      @(negedge clk_sys_i) chk({7'h0, irq}, {7'h0, e});
   endtask
   task automatic wt(input int i, input logic v, input int n);
      for (int k = 0; k < n; k++) begin
         @(negedge clk_sys_i);
         if (ch[i] === v) break;
      end
      chk({7'h0, ch[i]}, {7'h0, v});
      if (ch[i] !== v) wrap_up();
   endtask
   initial begin
      cyc(2);
      sys_rst_i <= 1'b0;
      rchk(REG_CMD, 8'hFF, CMD_RST);
      rchk(REG_IRQ_MASK, 8'hFF, IRQ_MASK_RST);
      rchk(4'hF, 8'hFF, 8'h00);
      rchk(REG_STAT, 8'hFF, 8'h00);
      chk({3'h0, pd}, 8'h1D);
      @(posedge clk_sys_i) want <= 3'b011;
      wrt(REG_CMD, 8'h07);
      cyc(4);
      chk_ch(8'h00);
      @(posedge clk_sys_i) want <= 3'b111;
      cyc(4);
      chk_ch(8'h00);
      @(posedge clk_sys_i) want <= 3'b100;
      cyc(2);
      @(posedge clk_sys_i) want <= 3'b111;
      wt(0, 1'b1, 6);
      wt(2, 1'b1, 2);
      for (int b = 0; b < 3; b++) begin
         wrt(REG_CMD, 8'h01 << b);
         cyc(3);
         rchk(REG_STAT, 8'hFF, 8'h05 | (8'h01 << map[b]));
      end
      wrt(REG_CMD, 8'h07);
      cyc(3);
      chk_ch(8'h1F);
      $display("test switching done");
      @(posedge clk_sys_i) sns.overtemp[3] <= 1'b1;
      cyc(3);
      chk_ch(8'h07);
      rchk(REG_DIAGNOSIS_REGISTER_OT, 8'hFF, 8'h18);
      @(posedge clk_sys_i) sns.overtemp[3] <= 1'b0;
      cyc(3);
      chk_ch(8'h1F);
      $display("test thermal done");
      @(posedge clk_sys_i) sns.overcurrent[0] <= 1'b1;
      cyc(30);
      chk_ch(8'h1F);
      wt(0, 1'b0, 20);
      @(posedge clk_sys_i) sns.overcurrent[0] <= 1'b0;
      cyc(6);
      chk_ch(8'h1E);
      rchk(REG_DIAGNOSIS_REGISTER_OC, 8'h01, 8'h01);
      wrt(REG_CMD, 8'h07);
      @(posedge clk_sys_i) rearm <= 1'b1;
      cyc(2);
      @(posedge clk_sys_i) rearm <= 1'b0;
      wt(0, 1'b1, 8);
      @(posedge clk_sys_i) sns.overcurrent[3] <= 1'b1;
      wt(3, 1'b0, 80);
      @(posedge clk_sys_i) sns.overcurrent[3] <= 1'b0;
      wrt(REG_CMD, 8'h07);
      cyc(3);
      chk_ch(8'h17);
      wrt(REG_DIAGNOSIS_REGISTER_CMD, 8'h00);
      wrt(REG_CMD, 8'h07);
      cyc(3);
      chk_ch(8'h1F);
      @(posedge clk_sys_i) sns.overcurrent[1] <= 1'b1;
      wt(1, 1'b0, 80);
      @(posedge clk_sys_i) sns.overcurrent[1] <= 1'b0;
      cyc(40);
      chk_ch(8'h1D);
      wt(1, 1'b1, 20);
      rchk(REG_DIAGNOSIS_REGISTER_OC, 8'h02, 8'h02);
      cyc(30);
      rchk(REG_DIAGNOSIS_REGISTER_OC, 8'h02, 8'h00);
      $display("test overcurrent done");
      wrt(REG_CMD, 8'h06);
      @(posedge clk_sys_i) want <= 3'b110;
      @(posedge clk_sys_i) sns.below_ol_threshold <= 5'b00110;
      cyc(1000);
      @(posedge clk_sys_i) sns.below_ol_threshold <= 5'b00010;
      @(posedge clk_sys_i) sns.below_ol_threshold <= 5'b00110;
      cyc(1900);
      rchk(REG_DIAGNOSIS_REGISTER_OL, 8'h06, 8'h00);
      chk({3'h0, pd}, 8'h04);
      cyc(150);
      rchk(REG_DIAGNOSIS_REGISTER_OL, 8'h06, 8'h04);
      $display("test open load done");
      wrt(REG_IRQ_MASK, 8'h00);
      ichk(1'b0);
      wrt(REG_IRQ_MASK, 8'h04);
      ichk(1'b1);
      @(posedge clk_sys_i) sns.below_ol_threshold <= 5'b00000;
      rchk(REG_IRQ_STAT, 8'h04, 8'h04);
      rchk(REG_IRQ_STAT, 8'h04, 8'h00);
      ichk(1'b0);
      $display("test interrupt done");
      wrap_up();
   end
endmodule // tb_lss_top
